// *** pkg/awdrp_pkg.sv ***
// Constants for the write data and write response port of the interconnect.
// Assumes a single clock and a synchronous active-low reset around the port.
package awdrp_pkg;

  localparam int unsigned DATA_W_DEF     = 32;
  localparam int unsigned DATA_W_MIN     = 32;
  localparam int unsigned DATA_W_MAX     = 256;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned RESP_W         = 2;
  localparam int unsigned SLV_ID_W_DEF   = 4;
  localparam int unsigned SLV_ID_W_MAX   = 16;
  localparam int unsigned MST_ID_W_DEF   = 8;
  localparam int unsigned MST_ID_W_MIN   = 1;
  localparam int unsigned MST_ID_W_MAX   = 24;
  localparam int unsigned USER_W_DEF     = 0;
  localparam int unsigned USER_W_MAX     = 256;
  localparam int unsigned PEND_W         = 8;
  localparam int unsigned BUF_CNT_W      = 2;
  localparam logic [1:0]  BUF_DEPTH      = 2'h2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam bit          ID_REDUCE_DEF  = 1'b0;

endpackage

// *** hdl/awdrp_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides sit on the same clock; all outputs come from flip-flops.
`timescale 1ns/1ns
`default_nettype none

module awdrp_buf #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  logic [awdrp_pkg::BUF_CNT_W-1:0] cnt_q;
  logic [awdrp_pkg::BUF_CNT_W-1:0] cnt_d;
  logic [WIDTH-1:0]                e0_q;
  logic [WIDTH-1:0]                e0_d;
  logic [WIDTH-1:0]                e1_q;
  logic [WIDTH-1:0]                e1_d;
  logic                            rdy_q;
  logic                            rdy_d;
  logic                            vld_q;
  logic                            vld_d;
  logic                            push;
  logic                            pop;

  always_comb begin
    push  = in_valid_in && rdy_q;
    pop   = vld_q && out_ready_in;
    cnt_d = cnt_q;
    e0_d  = e0_q;
    e1_d  = e1_q;
    case ({push, pop})
      2'b10: begin
        if (cnt_q == 2'h0) begin
          e0_d = in_data_in;
        end else begin
          e1_d = in_data_in;
        end
        cnt_d = cnt_q + 2'h1;
      end
      2'b01: begin
        e0_d  = e1_q;
        cnt_d = cnt_q - 2'h1;
      end
      2'b11: begin
        // Push is only possible below full, so the head is the only entry
        e0_d = in_data_in;
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    // Registered ready from the next count uses both slots; a pop when full frees room a cycle later
    rdy_d = (cnt_d < awdrp_pkg::BUF_DEPTH);
    vld_d = (cnt_d != 2'h0);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      e0_q  <= '0;
      e1_q  <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      e0_q  <= e0_d;
      e1_q  <= e1_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  assign in_ready_out  = rdy_q;
  assign out_valid_out = vld_q;
  assign out_data_out  = e0_q;

endmodule

`default_nettype wire

// *** hdl/awdrp_port.sv ***
// Write data and write response path of one interconnect port.
// Upstream side faces a write master, downstream side faces a write slave.
// Assumes one clock for both sides and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module awdrp_port #(
  parameter int unsigned DATA_W    = awdrp_pkg::DATA_W_DEF,
  parameter int unsigned SLV_ID_W  = awdrp_pkg::SLV_ID_W_DEF,
  parameter int unsigned MST_ID_W  = awdrp_pkg::MST_ID_W_DEF,
  parameter bit          ID_REDUCE = awdrp_pkg::ID_REDUCE_DEF,
  parameter int unsigned WUSER_W   = awdrp_pkg::USER_W_DEF,
  parameter int unsigned BUSER_W   = awdrp_pkg::USER_W_DEF,
  // Zero-width sidebands still need a one-bit port; it is tied off
  localparam int unsigned SIDP     = (SLV_ID_W == 0) ? 1 : SLV_ID_W,
  localparam int unsigned WUP      = (WUSER_W == 0) ? 1 : WUSER_W,
  localparam int unsigned BUP      = (BUSER_W == 0) ? 1 : BUSER_W,
  localparam int unsigned STRB_W   = DATA_W / awdrp_pkg::BYTE_BITS
) (
  // Clock and reset
  input  wire logic                          CLOCK_IN,
  input  wire logic                          RESETN_IN,
  // Slave-side interface block, write data in
  input  wire logic [SIDP-1:0]               S_WID_IN,
  input  wire logic [DATA_W-1:0]             S_WDATA_IN,
  input  wire logic [STRB_W-1:0]             S_WSTRB_IN,
  input  wire logic                          S_WLAST_IN,
  input  wire logic [WUP-1:0]                S_WUSER_IN,
  input  wire logic                          S_WVALID_IN,
  output logic                               S_WREADY_OUT,
  // Slave-side interface block, write response out
  output logic [SIDP-1:0]                    S_BID_OUT,
  output logic [awdrp_pkg::RESP_W-1:0]       S_BRESP_OUT,
  output logic [BUP-1:0]                     S_BUSER_OUT,
  output logic                               S_BVALID_OUT,
  input  wire logic                          S_BREADY_IN,
  // Master-side interface block, write data out
  output logic [MST_ID_W-1:0]                M_WID_OUT,
  output logic [DATA_W-1:0]                  M_WDATA_OUT,
  output logic [STRB_W-1:0]                  M_WSTRB_OUT,
  output logic                               M_WLAST_OUT,
  output logic [WUP-1:0]                     M_WUSER_OUT,
  output logic                               M_WVALID_OUT,
  input  wire logic                          M_WREADY_IN,
  // Master-side interface block, write response in
  input  wire logic [MST_ID_W-1:0]           M_BID_IN,
  input  wire logic [awdrp_pkg::RESP_W-1:0]  M_BRESP_IN,
  input  wire logic [BUP-1:0]                M_BUSER_IN,
  input  wire logic                          M_BVALID_IN,
  output logic                               M_BREADY_OUT,
  // Status
  output logic [awdrp_pkg::PEND_W-1:0]       PENDING_OUT,
  output logic                               ORPHAN_RESP_OUT
);

  // Word layouts through the buffers: write {id, user, last, strb, data}, response {id, user, resp}
  localparam int unsigned WWORD_W = MST_ID_W + WUP + 1 + STRB_W + DATA_W;
  localparam int unsigned BWORD_W = SIDP + BUP + awdrp_pkg::RESP_W;

  logic [DATA_W-1:0]             masked_data;
  logic [MST_ID_W-1:0]           down_id;
  logic [SIDP-1:0]               up_id;
  logic [WUP-1:0]                wuser_in;
  logic [BUP-1:0]                buser_in;
  logic [WWORD_W-1:0]            w_word_out;
  logic [BWORD_W-1:0]            b_word_out;
  logic                          s_wready;
  logic                          s_bvalid;
  logic [awdrp_pkg::PEND_W-1:0]  pend_q;
  logic [awdrp_pkg::PEND_W-1:0]  pend_d;
  logic                          orphan_q;
  logic                          orphan_d;
  logic                          burst_done;
  logic                          resp_done;

  for (genvar k = 0; k < STRB_W; k++) begin : g_lane
    assign masked_data[k*awdrp_pkg::BYTE_BITS +: awdrp_pkg::BYTE_BITS] =
      S_WSTRB_IN[k] ? S_WDATA_IN[k*awdrp_pkg::BYTE_BITS +: awdrp_pkg::BYTE_BITS]
                    : '0;
  end

  always_comb begin
    // Global width or reduction
    // Reduction keeps only the low bits; response IDs come back narrowed the same way
    down_id = '0;
    for (int i = 0; i < MST_ID_W; i++) begin
      if ((SLV_ID_W != 0) && (i < SLV_ID_W) && (ID_REDUCE || (i < MST_ID_W))) begin
        down_id[i] = S_WID_IN[i];
      end
    end
    up_id = '0;
    for (int i = 0; i < SIDP; i++) begin
      if ((SLV_ID_W != 0) && (i < MST_ID_W)) begin
        up_id[i] = M_BID_IN[i];
      end
    end
    wuser_in = (WUSER_W == 0) ? '0 : S_WUSER_IN;
    buser_in = (BUSER_W == 0) ? '0 : M_BUSER_IN;
  end

  awdrp_buf #(
    .WIDTH (WWORD_W)
  ) u_wbuf (
    .clk_in        (CLOCK_IN),
    .rst_n_in      (RESETN_IN),
    .in_valid_in   (S_WVALID_IN),
    .in_data_in    ({down_id, wuser_in, S_WLAST_IN, S_WSTRB_IN, masked_data}),
    .in_ready_out  (s_wready),
    .out_valid_out (M_WVALID_OUT),
    .out_data_out  (w_word_out),
    .out_ready_in  (M_WREADY_IN)
  );

  awdrp_buf #(
    .WIDTH (BWORD_W)
  ) u_bbuf (
    .clk_in        (CLOCK_IN),
    .rst_n_in      (RESETN_IN),
    .in_valid_in   (M_BVALID_IN),
    .in_data_in    ({up_id, buser_in, M_BRESP_IN}),
    .in_ready_out  (M_BREADY_OUT),
    .out_valid_out (s_bvalid),
    .out_data_out  (b_word_out),
    .out_ready_in  (S_BREADY_IN)
  );

  assign S_WREADY_OUT = s_wready;
  assign S_BVALID_OUT = s_bvalid;
  assign {M_WID_OUT, M_WUSER_OUT, M_WLAST_OUT, M_WSTRB_OUT, M_WDATA_OUT} = w_word_out;
  assign {S_BID_OUT, S_BUSER_OUT, S_BRESP_OUT} = b_word_out;

  always_comb begin
    burst_done = S_WVALID_IN && s_wready && S_WLAST_IN;
    resp_done  = s_bvalid && S_BREADY_IN;
    pend_d     = pend_q;
    orphan_d   = orphan_q;
    case ({burst_done, resp_done})
      2'b10: begin
        if (pend_q != '1) begin
          pend_d = pend_q + 1'b1;
        end
      end
      2'b01: begin
        if (pend_q == '0) begin
          orphan_d = 1'b1;
        end else begin
          pend_d = pend_q - 1'b1;
        end
      end
      default: begin
        pend_d = pend_q;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      pend_q   <= '0;
      orphan_q <= 1'b0;
    end else begin
      pend_q   <= pend_d;
      orphan_q <= orphan_d;
    end
  end

  assign PENDING_OUT     = pend_q;
  assign ORPHAN_RESP_OUT = orphan_q;

endmodule

`default_nettype wire

// *** verification/awdrp_port_properties.sv ***
// Checker for the write data and response port.
// Assumes binding into the port; sees only its pins.
`timescale 1ns/1ns
`default_nettype none
module awdrp_port_properties #(
  parameter int unsigned DATA_W   = 32,
  parameter int unsigned SLV_ID_W = 4,
  parameter int unsigned MST_ID_W = 8,
  localparam int unsigned SIDP    = (SLV_ID_W == 0) ? 1 : SLV_ID_W
) (
  // Clock, reset and handshakes
  input wire logic CLOCK_IN, RESETN_IN, S_WVALID_IN, S_WREADY_OUT, M_WVALID_OUT,
  input wire logic M_WREADY_IN, S_BVALID_OUT, S_BREADY_IN, M_BVALID_IN, M_BREADY_OUT,
  // Payloads
  input wire logic [SIDP-1:0]     S_WID_IN, S_BID_OUT,
  input wire logic [MST_ID_W-1:0] M_WID_OUT, M_BID_IN,
  input wire logic [DATA_W-1:0]   S_WDATA_IN, M_WDATA_OUT,
  input wire logic [DATA_W/8-1:0] S_WSTRB_IN, M_WSTRB_OUT,
  input wire logic [1:0]          S_BRESP_OUT, M_BRESP_IN
);
  logic [DATA_W-1:0] m_mask;
  always_comb begin
    for (int i = 0; i < DATA_W; i++) m_mask[i] = M_WSTRB_OUT[i/8];
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_rst_clear; $rose(RESETN_IN) |-> !M_WVALID_OUT && !S_BVALID_OUT; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("valid after reset");
  property p_w_stable; M_WVALID_OUT && !M_WREADY_IN |=> M_WVALID_OUT
    && $stable(M_WDATA_OUT) && $stable(M_WID_OUT); endproperty
  a_w_stable: assert property (p_w_stable) else $error("write beat dropped");
  property p_b_stable; S_BVALID_OUT && !S_BREADY_IN |=> S_BVALID_OUT
    && $stable(S_BRESP_OUT) && $stable(S_BID_OUT); endproperty
  a_b_stable: assert property (p_b_stable) else $error("response dropped");
  property p_w_zero; M_WVALID_OUT |-> (M_WDATA_OUT & ~m_mask) == '0; endproperty
  a_w_zero: assert property (p_w_zero) else $error("unstrobed byte set");
  property p_w_pass; S_WVALID_IN && S_WREADY_OUT && !M_WVALID_OUT |=> M_WVALID_OUT
    && M_WSTRB_OUT == $past(S_WSTRB_IN) && M_WDATA_OUT == ($past(S_WDATA_IN) & m_mask)
    && M_WID_OUT == MST_ID_W'($past(S_WID_IN)); endproperty
  a_w_pass: assert property (p_w_pass) else $error("write beat wrong");
  property p_b_pass; M_BVALID_IN && M_BREADY_OUT && !S_BVALID_OUT |=> S_BVALID_OUT
    && S_BRESP_OUT == $past(M_BRESP_IN) && S_BID_OUT == $past(M_BID_IN[SIDP-1:0]); endproperty
  a_b_pass: assert property (p_b_pass) else $error("response wrong");
  property p_w_room; M_WVALID_OUT && M_WREADY_IN |-> ##[1:2] S_WREADY_OUT; endproperty
  a_w_room: assert property (p_w_room) else $error("write ready stuck");
  property p_b_room; S_BVALID_OUT && S_BREADY_IN |-> ##[1:2] M_BREADY_OUT; endproperty
  a_b_room: assert property (p_b_room) else $error("response ready stuck");
endmodule
`default_nettype wire

// *** verification/awdrp_slave_model.sv ***
// Downstream write slave model for the port bench.
// Assumes one burst response outstanding at a time.
`timescale 1ns/1ns
`default_nettype none
module awdrp_slave_model (
  // Clock, reset and bench controls
  input wire logic       clk_in, rst_n_in, stall_in,
  input wire logic [1:0] resp_in,
  // Write data and response
  input wire logic [7:0] wid_in,
  input wire logic       wvalid_in, wlast_in, bready_in,
  output logic           wready_out, bvalid_out,
  output logic [7:0]     bid_out,
  output logic [1:0]     bresp_out
);
  // Registered ready, stall shows one edge late
  // One response per burst, held until taken
  always_ff @(posedge clk_in) begin
    wready_out <= rst_n_in && !stall_in;
    if (!rst_n_in) begin
      bvalid_out <= 1'b0;
      bid_out <= 8'h00;
      bresp_out <= 2'h0;
    end else if (bvalid_out && bready_in) begin
      // Released lines show the inverse, not a stale copy
      bvalid_out <= 1'b0;
      bid_out <= ~bid_out;
      bresp_out <= ~bresp_out;
    end else if (!bvalid_out && wvalid_in && wready_out && wlast_in) begin
      bvalid_out <= 1'b1;
      bid_out <= wid_in;
      bresp_out <= resp_in;
    end
  end
endmodule
`default_nettype wire

// *** verification/awdrp_port_tb.sv ***
// Bench for the write data and response port.
// Assumes the slave model on the downstream side.
`timescale 1ns/1ns
`default_nettype none
module awdrp_port_tb;
  logic clk, rst_n, s_wvalid, s_wlast, s_bready, stall, refused, s_wready, s_bvalid;
  logic m_wlast, m_wvalid, m_wready, m_bvalid, m_bready, orphan, s_buser, m_wuser;
  logic [3:0] s_wid, s_wstrb, s_bid, m_wstrb, last_id;
  logic [31:0] s_wdata, m_wdata;
  logic [1:0] resp, s_bresp, m_bresp;
  logic [7:0] m_wid, m_bid, pend;
  logic [44:0] e;
  logic [44:0] exp_q[$];
  int bad_count, checked, nb, n;
  // Rows: strobe, id, last, data; only the final beat closes the burst
  logic [40:0] rows [5] = '{{4'h0, 4'hf, 1'b0, 32'hffff_ffff}, {4'h5, 4'h3, 1'b0, 32'h89ab_cdef},
    {4'ha, 4'h9, 1'b0, 32'h1234_5678}, {4'h8, 4'h6, 1'b0, 32'hdead_beef},
    {4'hf, 4'he, 1'b1, 32'hcafe_f00d}};
  awdrp_port i_dut (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .S_WID_IN(s_wid), .S_WDATA_IN(s_wdata),
    .S_WSTRB_IN(s_wstrb), .S_WLAST_IN(s_wlast), .S_WUSER_IN(1'b0), .S_WVALID_IN(s_wvalid),
    .S_WREADY_OUT(s_wready), .S_BID_OUT(s_bid), .S_BRESP_OUT(s_bresp), .S_BUSER_OUT(s_buser),
    .S_BVALID_OUT(s_bvalid), .S_BREADY_IN(s_bready), .M_WID_OUT(m_wid), .M_WDATA_OUT(m_wdata),
    .M_WSTRB_OUT(m_wstrb), .M_WLAST_OUT(m_wlast), .M_WUSER_OUT(m_wuser), .M_WVALID_OUT(m_wvalid),
    .M_WREADY_IN(m_wready), .M_BID_IN(m_bid), .M_BRESP_IN(m_bresp), .M_BUSER_IN(1'b0),
    .M_BVALID_IN(m_bvalid), .M_BREADY_OUT(m_bready), .PENDING_OUT(pend), .ORPHAN_RESP_OUT(orphan));
  awdrp_slave_model i_slave (
    .clk_in(clk), .rst_n_in(rst_n), .stall_in(stall), .resp_in(resp), .wid_in(m_wid),
    .wvalid_in(m_wvalid), .wlast_in(m_wlast), .bready_in(m_bready), .wready_out(m_wready),
    .bvalid_out(m_bvalid), .bid_out(m_bid), .bresp_out(m_bresp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] mask(input logic [3:0] s);
    for (int i = 0; i < 32; i++) mask[i] = s[i/8];
  endfunction
  task automatic fail(input string m);
    $display("ERROR %0t %s", $time, m);
    bad_count++;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic send(input logic [40:0] r);
    s_wvalid <= 1'b1;
    {s_wstrb, s_wid, s_wlast, s_wdata} <= r;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_wready !== 1'b1 && n < 50);
    if (s_wready !== 1'b1) begin
      fail("write timeout");
      end_of_test();
    end
    exp_q.push_back({r[40:37], r[32], 4'h0, r[36:33], r[31:0] & mask(r[40:37])});
  endtask
  task automatic drain(input int want);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((exp_q.size() != 0 || nb != want) && n < 200);
    if (exp_q.size() != 0 || nb != want) begin
      fail("drain timeout");
      end_of_test();
    end
  endtask
  // Slow response acceptance exercises the response buffer
  always @(posedge clk) s_bready <= rst_n && !s_bready;
  always @(posedge clk) begin
    if (!rst_n) refused <= 1'b0;
    else if (s_wvalid && !s_wready) refused <= 1'b1;
    if (m_wvalid && m_wready) begin
      if (exp_q.size() == 0) fail("extra beat");
      else begin
        e = exp_q.pop_front();
        checked += 4;
        if (m_wdata !== e[31:0]) fail("wdata");
        if (m_wid !== e[39:32]) fail("wid");
        if (m_wlast !== e[40]) fail("wlast");
        if (m_wstrb !== e[44:41]) fail("wstrb");
      end
    end
    if (s_bvalid && s_bready) begin
      nb++;
      checked += 3;
      if (s_bresp !== resp) fail("bresp");
      if (s_bid !== last_id) fail("bid");
      if (s_buser !== 1'b0 || m_wuser !== 1'b0) fail("user");
    end
  end
  initial begin
    rst_n = 1'b0; s_wvalid = 1'b0; s_wlast = 1'b0; s_wid = 4'h0; s_wstrb = 4'h0;
    s_wdata = 32'h0000_0000; stall = 1'b0; resp = 2'h0;
    last_id = 4'he;
    repeat (2) @(posedge clk);
    checked += 2;
    if (m_wvalid !== 1'b0 || s_wready !== 1'b0) fail("reset");
    if (s_bvalid !== 1'b0 || pend !== 8'h00) fail("reset");
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) send(rows[i]);
    s_wvalid <= 1'b0;
    drain(1);
    // Downstream stalls so the buffer fills and refuses; every response code once
    for (int c = 0; c < 4; c++) begin
      resp <= c[1:0];
      last_id <= 4'(c + 5);
      stall <= 1'b1;
      fork
        begin
          repeat (8) @(posedge clk);
          stall <= 1'b0;
        end
      join_none
      for (int b = 0; b < 4; b++) send({4'h1 << b, 4'(c + 5), b == 3, 8'(c), 8'(b), 16'ha5c3});
      s_wvalid <= 1'b0;
      @(posedge clk);
      checked++;
      if (pend !== 8'h01) fail("pending count");
      drain(c + 2);
    end
    @(posedge clk);
    checked += 2;
    if (refused !== 1'b1) fail("no refusal");
    if (pend !== 8'h00 || orphan !== 1'b0) fail("status");
    end_of_test();
  end
endmodule
bind awdrp_port awdrp_port_properties #(.DATA_W(DATA_W), .SLV_ID_W(SLV_ID_W),
  .MST_ID_W(MST_ID_W)) i_prop (.*);
`default_nettype wire
